// ### verilog/fwkl_lock.sv
`timescale 1ns/1ps
module fwkl_lock
  import fwkl_pkg::*;
(
  input wire logic clk_sys, // 25 MHz system clock
  input wire logic reset_n, // Asynchronous device reset
  input wire fwkl_sfr_req_t sfr_req, // Register access from the core
  output logic [7:0] sfr_rdata, // Read data, registered
  output logic sfr_hit, // Read data valid this cycle
  input wire fwkl_xwr_t xwr, // External data move write
  output logic xwr_to_flash, // Move write is routed to flash
  output fwkl_flash_cmd_t flash_cmd, // Command to flash array, registered
  input wire logic flash_done, // Flash operation finished pulse
  output logic flash_busy, // Flash operation in progress
  output logic [1:0] lock_state // Current lock code
);

  typedef struct packed {
    fwkl_lock_t lock;
    logic erase_en;
    logic write_en;
    logic busy;
    logic hit;
    logic [7:0] rdata;
    fwkl_flash_cmd_t cmd;
  } fwkl_state_t;

  fwkl_state_t state;
  fwkl_state_t next_state;

  function automatic logic [1:0] lock_code(input fwkl_lock_t s);
    case (s)
      FWKL_LOCKED: lock_code = FWKL_CODE_LOCKED;
      FWKL_FIRST_KEY: lock_code = FWKL_CODE_FIRST;
      FWKL_OPEN: lock_code = FWKL_CODE_OPEN;
      default: lock_code = FWKL_CODE_TRAPPED;
    endcase
  endfunction : lock_code

  logic key_sel;
  logic ctl_sel;
  logic key_wr;
  logic ctl_wr;
  logic map_rd;
  logic flash_attempt;
  logic move_ok;
  logic op_end;

  // Next lock state after one key register write
  function automatic fwkl_lock_t key_step(
    input fwkl_lock_t s,
    input logic [7:0] d
  );
    case (s)
      FWKL_LOCKED:
      begin
        key_step = (d == FWKL_KEY_FIRST) ? FWKL_FIRST_KEY : FWKL_TRAPPED;
      end
      FWKL_FIRST_KEY:
      begin
        key_step = (d == FWKL_KEY_SECOND) ? FWKL_OPEN : FWKL_TRAPPED;
      end
      FWKL_OPEN:
      begin
        key_step = FWKL_TRAPPED;
      end
      default:
      begin
        key_step = FWKL_TRAPPED;
      end
    endcase
  endfunction : key_step

  // Erase works on whole pages, so the low address bits carry no meaning
  function automatic logic [FWKL_ADDR_W-1:0] page_base(input logic [FWKL_ADDR_W-1:0] a);
    page_base = a;
    page_base[FWKL_PAGE_BITS-1:0] = '0;
  endfunction : page_base

  // Unmapped addresses read as zero
  function automatic logic [7:0] read_word(
    input logic ksel,
    input logic csel,
    input fwkl_lock_t s,
    input logic we,
    input logic ee
  );
    read_word = '0;
    if (ksel)
    begin
      read_word = 8'(lock_code(s));
    end
    else if (csel)
    begin
      read_word[FWKL_WE_BIT] = we;
      read_word[FWKL_EE_BIT] = ee;
    end
  endfunction : read_word

  // Command for an accepted move write
  function automatic fwkl_flash_cmd_t move_cmd(
    input logic erase,
    input logic [FWKL_ADDR_W-1:0] a,
    input logic [7:0] d
  );
    move_cmd = '0;
    if (erase)
    begin
      move_cmd.erase = 1'b1;
      move_cmd.addr = page_base(a);
    end
    else
    begin
      move_cmd.write = 1'b1;
      move_cmd.addr = a;
      move_cmd.data = d;
    end
  endfunction : move_cmd

  assign key_sel = sfr_req.addr == FWKL_KEY_ADDR;
  assign ctl_sel = (sfr_req.addr == FWKL_PSCTL_ADDR) && (sfr_req.page == FWKL_PSCTL_PAGE);
  assign key_wr = sfr_req.wr && key_sel;
  assign ctl_wr = sfr_req.wr && ctl_sel;
  assign map_rd = sfr_req.rd && (key_sel || ctl_sel);
  assign xwr_to_flash = state.write_en;
  assign flash_attempt = xwr.wr && state.write_en;
  // a busy lock counts as closed, so a second move traps it
  assign move_ok = flash_attempt && (state.lock == FWKL_OPEN) && !state.busy;
  assign op_end = state.busy && flash_done;

  // Read strobes and command pulses last one cycle; the rest is held
  always_comb
  begin
    next_state = state;
    next_state.hit = 1'b0;
    next_state.cmd.write = 1'b0;
    next_state.cmd.erase = 1'b0;
    // Read data holds until the next read so a slow reader still sees it
    if (sfr_req.rd)
    begin
      next_state.hit = map_rd;
      next_state.rdata = read_word(key_sel, ctl_sel, state.lock,
                                   state.write_en, state.erase_en);
    end
    // Enables are plain storage and never touch the lock
    if (ctl_wr)
    begin
      next_state.write_en = sfr_req.wdata[FWKL_WE_BIT];
      next_state.erase_en = sfr_req.wdata[FWKL_EE_BIT];
    end
    if (key_wr)
    begin
      next_state.lock = key_step(state.lock, sfr_req.wdata);
    end
    if (move_ok)
    begin
      next_state.busy = 1'b1;
      next_state.cmd = move_cmd(state.erase_en, xwr.addr, xwr.data);
    end
    else if (flash_attempt)
    begin
      next_state.lock = FWKL_TRAPPED;
    end
    // A trap raised in the cycle an operation ends must win over the relock
    if (op_end)
    begin
      next_state.busy = 1'b0;
      if (next_state.lock == FWKL_OPEN)
      begin
        next_state.lock = FWKL_LOCKED;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= '{
        lock: FWKL_LOCKED,
        erase_en: FWKL_PSCTL_RESET[FWKL_EE_BIT],
        write_en: FWKL_PSCTL_RESET[FWKL_WE_BIT],
        busy: 1'b0,
        hit: 1'b0,
        rdata: FWKL_KEY_RESET,
        cmd: '0
      };
    end
    else
    begin
      state <= next_state;
    end
  end

  assign sfr_rdata = state.rdata;
  assign sfr_hit = state.hit;
  assign flash_cmd = state.cmd;
  assign flash_busy = state.busy;
  assign lock_state = lock_code(state.lock);

endmodule : fwkl_lock

// ### include/fwkl_pkg.sv
package fwkl_pkg;

  // Special function register map
  localparam logic [7:0] FWKL_KEY_ADDR = 8'hB7;
  localparam logic [7:0] FWKL_PSCTL_ADDR = 8'h8F;
  localparam logic [3:0] FWKL_PSCTL_PAGE = 4'h0;
  localparam logic [7:0] FWKL_KEY_RESET = 8'h00;
  localparam logic [7:0] FWKL_PSCTL_RESET = 8'h00;

  // Key sequence values
  localparam logic [7:0] FWKL_KEY_FIRST = 8'hA5;
  localparam logic [7:0] FWKL_KEY_SECOND = 8'hF1;

  // Control field positions
  localparam int FWKL_WE_BIT = 0;
  localparam int FWKL_EE_BIT = 1;

  // Flash geometry
  localparam int FWKL_ADDR_W = 15;
  localparam int FWKL_PAGE_BITS = 9;

  // Reported lock state codes
  localparam logic [1:0] FWKL_CODE_LOCKED = 2'h0;
  localparam logic [1:0] FWKL_CODE_FIRST = 2'h1;
  localparam logic [1:0] FWKL_CODE_OPEN = 2'h2;
  localparam logic [1:0] FWKL_CODE_TRAPPED = 2'h3;

  typedef enum logic [1:0] {
    FWKL_LOCKED,
    FWKL_FIRST_KEY,
    FWKL_OPEN,
    FWKL_TRAPPED
  } fwkl_lock_t;

  // Processor special function register access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [3:0] page;
    logic [7:0] wdata;
  } fwkl_sfr_req_t;

  // External data move write from the core
  typedef struct packed {
    logic wr;
    logic [FWKL_ADDR_W-1:0] addr;
    logic [7:0] data;
  } fwkl_xwr_t;

  // Command toward the flash array
  typedef struct packed {
    logic write;
    logic erase;
    logic [FWKL_ADDR_W-1:0] addr;
    logic [7:0] data;
  } fwkl_flash_cmd_t;

endpackage : fwkl_pkg

// ### sim/fwkl_flash_model.sv
`timescale 1ns/1ps
module fwkl_flash_model
  import fwkl_pkg::*;
(
  input wire logic clk_sys, // Clock
  input wire logic reset_n, // Reset
  input wire fwkl_flash_cmd_t flash_cmd, // Command
  input wire logic [3:0] dly, // Busy cycles
  output logic flash_done // End pulse
);
  logic [3:0] cnt;
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
    begin
      cnt <= 4'h0;
      flash_done <= 1'b0;
    end
    else
    begin
      flash_done <= cnt == 4'h1;
      cnt <= (flash_cmd.write || flash_cmd.erase) ? dly : cnt - (cnt != 4'h0);
    end
endmodule : fwkl_flash_model

// ### sim/fwkl_lock_properties.sv
`timescale 1ns/1ps
module fwkl_lock_properties
  import fwkl_pkg::*;
(
  input wire logic clk_sys, // Clock
  input wire logic reset_n, // Reset
  input wire fwkl_sfr_req_t sfr_req, // Access
  input wire logic [7:0] sfr_rdata, // Read data
  input wire logic sfr_hit, // Read valid
  input wire fwkl_xwr_t xwr, // Move
  input wire logic xwr_to_flash, // To flash
  input wire fwkl_flash_cmd_t flash_cmd, // Command
  input wire logic flash_done, // Done
  input wire logic flash_busy, // Busy
  input wire logic [1:0] lock_state // Lock code
);
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  wire kw = sfr_req.wr && sfr_req.addr == FWKL_KEY_ADDR;
  wire mv = xwr.wr && xwr_to_flash;
  trap_sticky_a: assert property (lock_state == 2'h3 |=> lock_state == 2'h3)
    else $error("trap left");
  key_first_a: assert property (kw && !mv && lock_state == 2'h0 && sfr_req.wdata == 8'hA5
    |=> lock_state == 2'h1) else $error("no first");
  bad_key_a: assert property (kw && lock_state == 2'h0 && sfr_req.wdata != 8'hA5
    |=> lock_state == 2'h3) else $error("no trap");
  read_code_a: assert property (sfr_req.rd && sfr_req.addr == FWKL_KEY_ADDR
    |=> sfr_hit && sfr_rdata == {6'h00, $past(lock_state)}) else $error("bad read");
  relock_a: assert property (flash_done && flash_busy && lock_state == 2'h2 && !kw
    && !xwr.wr |=> lock_state == 2'h0) else $error("no relock");
  cmd_issue_a: assert property (mv && lock_state == 2'h2 && !flash_busy
    |=> flash_busy && (flash_cmd.write ^ flash_cmd.erase)
    && (flash_cmd.erase || flash_cmd.addr == $past(xwr.addr))
    && (flash_cmd.erase || flash_cmd.data == $past(xwr.data))) else $error("no cmd");
  erase_page_a: assert property (flash_cmd.erase
    |-> flash_cmd.addr[8:0] == 9'h000 && flash_cmd.data == 8'h00) else $error("bad erase");
  attempt_trap_a: assert property (mv && lock_state != 2'h2
    |=> lock_state == 2'h3 && !flash_cmd.write && !flash_cmd.erase) else $error("no block");
endmodule : fwkl_lock_properties
bind fwkl_lock fwkl_lock_properties u_prop (
  .clk_sys(clk_sys),
  .reset_n(reset_n),
  .sfr_req(sfr_req),
  .sfr_rdata(sfr_rdata),
  .sfr_hit(sfr_hit),
  .xwr(xwr),
  .xwr_to_flash(xwr_to_flash),
  .flash_cmd(flash_cmd),
  .flash_done(flash_done),
  .flash_busy(flash_busy),
  .lock_state(lock_state)
);

// ### sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import fwkl_pkg::*;
  logic clk_sys = 0;
  logic reset_n = 0;
  logic [3:0] dly = 4'h1;
  fwkl_sfr_req_t sfr_req = '0;
  fwkl_xwr_t xwr = '0;
  logic [7:0] sfr_rdata, bad;
  logic sfr_hit, xwr_to_flash, flash_busy, flash_done;
  logic [1:0] lock_state;
  fwkl_flash_cmd_t flash_cmd;
  logic [7:0] exp_q[$];
  fwkl_flash_cmd_t cmd_q[$];
  fwkl_flash_cmd_t exp_cmd;
  int failures = 0;
  int n_checks = 0;
  always #20 clk_sys = ~clk_sys;
  fwkl_lock DUT (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit),
    .xwr(xwr),
    .xwr_to_flash(xwr_to_flash),
    .flash_cmd(flash_cmd),
    .flash_done(flash_done),
    .flash_busy(flash_busy),
    .lock_state(lock_state)
  );
  fwkl_flash_model FLASH (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .flash_cmd(flash_cmd),
    .dly(dly),
    .flash_done(flash_done)
  );
  task automatic complete_run;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    sfr_req = '{w, !w, a, (a == FWKL_KEY_ADDR) ? 4'($urandom) : 4'h0, d};
    @(posedge clk_sys);
    #1;
    sfr_req = '0;
  endtask : bus
  task automatic rd(input logic [7:0] e, input logic [7:0] a = FWKL_KEY_ADDR);
    exp_q.push_back(e);
    bus(0, a, 8'h00);
    if (a == FWKL_KEY_ADDR)
      check("lock_state", 32'(lock_state), 32'(e[1:0]));
  endtask : rd
  task automatic mv(input logic [1:0] m);
    fwkl_flash_cmd_t c;
    @(posedge clk_sys);
    #1;
    dly = 4'h1 + 4'($urandom % 8);
    xwr = '{1'b1, 15'($urandom), 8'($urandom)};
    c = '{m == 2'h1, m == 2'h3, xwr.addr, xwr.data};
    if (m == 2'h3)
    begin
      c.addr[FWKL_PAGE_BITS-1:0] = '0;
      c.data = 8'h00;
    end
    if (m != 2'h0)
      cmd_q.push_back(c);
    check("xwr_to_flash", 32'(xwr_to_flash), 32'h1);
    @(posedge clk_sys);
    #1;
    xwr = '0;
    for (int i = 0; i < 20 && flash_busy !== 1'b0; i++) @(negedge clk_sys);
    check("flash_busy", 32'(flash_busy), 32'h0);
  endtask : mv
  task automatic rst;
    @(posedge clk_sys);
    #1;
    reset_n = 0;
    repeat (10) @(posedge clk_sys);
    #1;
    reset_n = 1;
  endtask : rst
  always @(negedge clk_sys)
  begin
    if (sfr_hit === 1'b1)
      check("sfr_rdata", 32'(sfr_rdata), 32'(exp_q.pop_front()));
    if (flash_cmd.write === 1'b1 || flash_cmd.erase === 1'b1)
    begin
      exp_cmd = (cmd_q.size() > 0) ? cmd_q.pop_front() : '0;
      check("flash_cmd", 32'(flash_cmd), 32'(exp_cmd));
    end
  end
  initial
  begin
    #100000;
    failures++;
    complete_run();
  end
  initial
  begin
    void'($urandom(57313));
    rst();
    rd(8'h00);
    for (int e = 1; e <= 3; e += 2)
    begin
      bus(1, FWKL_KEY_ADDR, FWKL_KEY_FIRST);
      rd(8'h01);
      bus(1, FWKL_KEY_ADDR, FWKL_KEY_SECOND);
      rd(8'h02);
      bus(1, FWKL_PSCTL_ADDR, 8'(e));
      rd(8'(e), FWKL_PSCTL_ADDR);
      mv(2'(e));
      rd(8'h00);
    end
    $display("test write and erase done");
    mv(2'h0);
    rd(8'h03);
    bus(1, FWKL_KEY_ADDR, FWKL_KEY_FIRST);
    rd(8'h03);
    for (int k = 0; k < 2; k++)
    begin
      rst();
      bad = 8'($urandom % 165);
      if (k == 1)
        bus(1, FWKL_KEY_ADDR, FWKL_KEY_FIRST);
      bus(1, FWKL_KEY_ADDR, bad);
      rd(8'h03);
    end
    $display("test trap done");
    repeat (3) @(posedge clk_sys);
    check("pending", 32'(exp_q.size() + cmd_q.size()), 32'h0);
    complete_run();
  end
endmodule : testbench
